// >>> hw/mlfc_top.sv
// Purpose: Motor lock fault settings register and lock fault gating.
// Assumes: Host access arrives as a word write/read strobe port at offset 0x92.
// Notes: Threshold codes are decoded here into comparison levels for detectors.
// Function
// - 32-bit RW settings word, zero at reset
// - Bit 30 enables overspeed lock detector
// - Bit 29 enables weak back-EMF lock
// - Bit 28 enables absent-motor lock detector
// - Overspeed trip 130 to 200 percent
// - Back-EMF trip 40 to 70 percent
// - Absent-motor current level code table
// - Current clamp response: latch, retry, off
// - Current clamp deglitch 0 to 7 us
// - Report-only mode asserts fault, no braking
`timescale 1ns/10ps
`default_nettype none
module mlfc_top
  import mlfc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic overspeed_hit,
  input wire logic weak_backemf_hit,
  input wire logic absent_motor_hit,
  input wire logic clamp_hit,
  input wire logic lock_retry_tick,
  input wire logic fault_clear,
  input wire logic [3:0] lock_response_select,
  output logic [7:0] overspeed_trip_pct,
  output logic [9:0] weak_backemf_trip_permille,
  output logic [9:0] absent_motor_current_ma,
  output logic [2:0] lock_flags,
  output logic clamp_fault,
  output mlfc_action_type gate_action,
  output logic fault_out_n
);
  logic [31:0] fault_settings_two_q; // The settings word itself.
  logic [1:0] hit_s1_q; // First synchroniser stage for lock events.
  logic [1:0] hit_s2_q; // Second stage, the only stage logic reads.
  logic [2:0] flags_d; // Gated lock events.
  logic clamp_latched_q; // Latched current clamp fault.
  logic [2:0] retry_q; // Retries spent in auto-retry modes.
  logic [3:0] clamp_resp; // Current clamp response field.
  logic [2:0] retry_limit_count; // Allowed retries.
  logic clamp_evt; // Filtered clamp event.
  logic any_lock; // Any lock or clamp fault standing.
  mlfc_cfg_if cfg_bus();

  // Overspeed and back-EMF come from detector logic on this clock; the
  // absent-motor and clamp comparators are analog and need synchronising.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hit_s1_q <= 2'h0;
      hit_s2_q <= 2'h0;
    end else if (clk_en) begin
      hit_s1_q <= {clamp_hit, absent_motor_hit};
      hit_s2_q <= hit_s1_q;
    end
  end

  // Register write port; every bit, the reserved ones included, stores.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_settings_two_q <= MLFC_SETTINGS_RESET;
    end else if (clk_en && cfg_wr && cfg_addr == MLFC_SETTINGS_OFFSET) begin
      fault_settings_two_q <= cfg_wdata;
    end
  end

  // Read answers one cycle later; unmapped offsets read as zero.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_rdata <= 32'h00000000;
      cfg_rvalid <= 1'b0;
    end else if (clk_en) begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd && cfg_addr == MLFC_SETTINGS_OFFSET) begin
        cfg_rdata <= fault_settings_two_q;
      end else begin
        cfg_rdata <= 32'h00000000;
      end
    end
  end

  // Overspeed level: 130 percent plus ten per code step.
  function automatic logic [7:0] mlfc_speed_pct(input logic [2:0] code);
    mlfc_speed_pct = 8'(130 + 10 * int'(code));
  endfunction

  // Back-EMF level in tenths of a percent; codes 6 and 7 break the step.
  function automatic logic [9:0] mlfc_bemf_pm(input logic [2:0] code);
    case (code)
      3'h6: mlfc_bemf_pm = 10'd675;
      3'h7: mlfc_bemf_pm = 10'd700;
      default: mlfc_bemf_pm = 10'(400 + 50 * int'(code));
    endcase
  endfunction

  // Absent-motor current in milliamps; codes 0 and 1 share a level.
  function automatic logic [9:0] mlfc_absent_ma(input logic [2:0] code);
    case (code)
      3'h0, 3'h1: mlfc_absent_ma = 10'd75;
      3'h2: mlfc_absent_ma = 10'd100;
      3'h3: mlfc_absent_ma = 10'd125;
      3'h4: mlfc_absent_ma = 10'd250;
      3'h5: mlfc_absent_ma = 10'd500;
      3'h6: mlfc_absent_ma = 10'd750;
      default: mlfc_absent_ma = 10'd1000;
    endcase
  endfunction

  // Brake or tristate action for a latched/retry code.
  function automatic mlfc_action_type mlfc_action(input logic [3:0] code);
    case (code[1:0])
      2'h2: mlfc_action = MLFC_ACT_HS_BRAKE;
      2'h3: mlfc_action = MLFC_ACT_LS_BRAKE;
      default: mlfc_action = MLFC_ACT_TRISTATE;
    endcase
  endfunction

  // Field views of the settings word.
  always_comb begin
    clamp_resp = fault_settings_two_q[MLFC_CLAMP_RESP_LSB +: 4];
    retry_limit_count = fault_settings_two_q[MLFC_RETRY_LSB +: 3];
    cfg_bus.filt_code = fault_settings_two_q[MLFC_CLAMP_FILT_LSB +: 3];
    cfg_bus.raw_event = hit_s2_q[1] && clamp_resp < MLFC_RESP_REPORT;
    // The filter output lags the field by a cycle, so the disable is applied
    // again here; a code of 8 or above must never let a late event latch.
    clamp_evt = cfg_bus.clean_event && clamp_resp < MLFC_RESP_REPORT;
  end

  // Each detector fault is masked by its own enable bit.
  always_comb begin
    flags_d[2] = overspeed_hit && fault_settings_two_q[MLFC_OVERSPEED_EN_BIT];
    flags_d[1] = weak_backemf_hit && fault_settings_two_q[MLFC_BACKEMF_EN_BIT];
    flags_d[0] = hit_s2_q[0] && fault_settings_two_q[MLFC_ABSENT_EN_BIT];
  end

  mlfc_deglitch u_deglitch (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .cfg(cfg_bus.filt)
  );

  // Decoded trip levels and gated flags are registered outputs.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      overspeed_trip_pct <= 8'h00;
      weak_backemf_trip_permille <= 10'h000;
      absent_motor_current_ma <= 10'h000;
      lock_flags <= 3'h0;
    end else if (clk_en) begin
      overspeed_trip_pct <= mlfc_speed_pct(fault_settings_two_q[MLFC_OVERSPEED_LVL_LSB +: 3]);
      weak_backemf_trip_permille <= mlfc_bemf_pm(fault_settings_two_q[MLFC_BACKEMF_LVL_LSB +: 3]);
      absent_motor_current_ma <= mlfc_absent_ma(fault_settings_two_q[MLFC_ABSENT_LVL_LSB +: 3]);
      lock_flags <= flags_d;
    end
  end

  // Clamp fault latches; retry modes clear it on the retry tick until the
  // limit is spent, after which it stays latched. A new event beats a clear.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clamp_latched_q <= 1'b0;
      retry_q <= 3'h0;
    end else if (clk_en) begin
      if (clamp_evt) begin
        clamp_latched_q <= 1'b1;
      end else if (fault_clear) begin
        clamp_latched_q <= 1'b0;
        retry_q <= 3'h0;
      end else if (clamp_latched_q && lock_retry_tick && clamp_resp >= MLFC_RESP_RETRY_LO
                   && retry_q < retry_limit_count) begin
        clamp_latched_q <= 1'b0;
        retry_q <= retry_q + 3'h1;
      end
    end
  end

  always_comb begin
    any_lock = clamp_latched_q || (|flags_d);
  end

  // Fault pin and gate action; report-only leaves the outputs running.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_out_n <= 1'b1;
      gate_action <= MLFC_ACT_NONE;
      clamp_fault <= 1'b0;
    end else if (clk_en) begin
      fault_out_n <= !any_lock;
      clamp_fault <= clamp_latched_q;
      if (clamp_latched_q) begin
        gate_action <= mlfc_action(clamp_resp);
      end else if ((|flags_d) && lock_response_select < MLFC_RESP_REPORT) begin
        gate_action <= mlfc_action(lock_response_select);
      end else begin
        gate_action <= MLFC_ACT_NONE;
      end
    end
  end

  // Checks on the register path, the detector gating and the response modes.
  a_write_then_read: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && cfg_wr && cfg_addr == MLFC_SETTINGS_OFFSET ##1 clk_en && cfg_rd
      && cfg_addr == MLFC_SETTINGS_OFFSET && !cfg_wr ##1 clk_en
      |-> cfg_rdata == $past(cfg_wdata, 2) && cfg_rvalid)
    else $error("Settings word did not read back.");
  a_overspeed_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && !fault_settings_two_q[MLFC_OVERSPEED_EN_BIT] |=> !lock_flags[2])
    else $error("Overspeed flag raised while disabled.");
  a_backemf_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && fault_settings_two_q[MLFC_BACKEMF_EN_BIT] && weak_backemf_hit
      |=> lock_flags[1])
    else $error("Enabled back-EMF hit not flagged.");
  a_absent_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && !fault_settings_two_q[MLFC_ABSENT_EN_BIT] |=> !lock_flags[0])
    else $error("Absent-motor flag raised while disabled.");
  a_speed_level: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && fault_settings_two_q[MLFC_OVERSPEED_LVL_LSB +: 3] == 3'h7
      |=> overspeed_trip_pct == 8'd200)
    else $error("Overspeed level wrong for top code.");
  a_bemf_level: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && fault_settings_two_q[MLFC_BACKEMF_LVL_LSB +: 3] == 3'h6
      |=> weak_backemf_trip_permille == 10'd675)
    else $error("Back-EMF level wrong for code six.");
  a_absent_level: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && fault_settings_two_q[MLFC_ABSENT_LVL_LSB +: 3] == 3'h1
      |=> absent_motor_current_ma == 10'd75)
    else $error("Absent-motor level wrong for code one.");
  a_clamp_disabled: assert property (@(posedge core_clk) disable iff (!rst_b)
    clamp_resp >= MLFC_RESP_REPORT && !clamp_latched_q |=> !clamp_latched_q)
    else $error("Clamp fault raised while disabled.");
  a_report_only: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && !clamp_latched_q && lock_response_select == MLFC_RESP_REPORT && (|flags_d)
      |=> !fault_out_n && gate_action == MLFC_ACT_NONE)
    else $error("Report-only mode stopped the outputs.");
endmodule
`default_nettype wire

// >>> hw/mlfc_pkg.sv
// Purpose: Constants for the motor lock fault settings register block.
// Assumes: One 32-bit register reached by a word-wide configuration port.
// Notes: Field positions, codes, reset value and timing counts live here.
package mlfc_pkg;
  localparam logic [7:0] MLFC_SETTINGS_OFFSET = 8'h92;
  localparam logic [31:0] MLFC_SETTINGS_RESET = 32'h00000000;
  localparam int MLFC_OVERSPEED_EN_BIT = 30;
  localparam int MLFC_BACKEMF_EN_BIT = 29;
  localparam int MLFC_ABSENT_EN_BIT = 28;
  localparam int MLFC_OVERSPEED_LVL_LSB = 25;
  localparam int MLFC_BACKEMF_LVL_LSB = 22;
  localparam int MLFC_ABSENT_LVL_LSB = 19;
  localparam int MLFC_CLAMP_RESP_LSB = 15;
  localparam int MLFC_CLAMP_FILT_LSB = 12;
  localparam int MLFC_RETRY_LSB = 0;
  localparam logic [3:0] MLFC_RESP_REPORT = 4'h8;
  localparam logic [3:0] MLFC_RESP_RETRY_LO = 4'h4;
  // Deglitch step of one microsecond at a 10 ns clock period.
  localparam int MLFC_FILT_STEP_NS = 1000;
  localparam int MLFC_CLK_PERIOD_NS = 10;
  localparam int MLFC_FILT_STEP_CYC = MLFC_FILT_STEP_NS / MLFC_CLK_PERIOD_NS;
  // Response actions driven to the gate stage.
  typedef enum logic [1:0] {
    MLFC_ACT_NONE,
    MLFC_ACT_TRISTATE,
    MLFC_ACT_HS_BRAKE,
    MLFC_ACT_LS_BRAKE
  } mlfc_action_type;
endpackage

// >>> hw/mlfc_cfg_if.sv
// Purpose: Carrier for decoded settings between register and filter logic.
// Assumes: Single clock domain.
// Notes: The top module keeps plain ports.
`timescale 1ns/10ps
`default_nettype none
interface mlfc_cfg_if;
  logic [2:0] filt_code; // Deglitch setting in microseconds.
  logic raw_event; // Unfiltered current clamp event.
  logic clean_event; // Event after deglitch.
  modport ctrl (output filt_code, output raw_event, input clean_event);
  modport filt (input filt_code, input raw_event, output clean_event);
endinterface
`default_nettype wire

// >>> hw/mlfc_deglitch.sv
// Purpose: Deglitch filter for the current clamp lock event.
// Assumes: Event input is already synchronous to core_clk.
// Notes: Code 0 passes the event straight to the flop with no filtering.
`timescale 1ns/10ps
`default_nettype none
module mlfc_deglitch
  import mlfc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  mlfc_cfg_if.filt cfg
);
  logic [11:0] run_q; // Cycles the event has stood high.
  logic [11:0] need; // Cycles required before the event is accepted.

  // Required length scales with the code; zero means no deglitch.
  always_comb begin
    need = 12'(int'(cfg.filt_code) * MLFC_FILT_STEP_CYC);
  end

  // Count while the event stands; any drop restarts the count.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= 12'h000;
      cfg.clean_event <= 1'b0;
    end else if (clk_en) begin
      if (!cfg.raw_event) begin
        run_q <= 12'h000;
        cfg.clean_event <= 1'b0;
      end else begin
        if (run_q < need) begin
          run_q <= run_q + 12'h001;
        end
        cfg.clean_event <= (run_q >= need);
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/mlfc_host_model.sv
// Purpose: Host controller model that writes and reads the fault settings word.
// Assumes: Word-wide strobe port, one request taken per enabled rising edge.
// Notes: Released write data shows the inverse so stale values cannot pass.
`timescale 1ns/10ps
`default_nettype none
module mlfc_host_model (
  input wire logic core_clk,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_addr,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid
);
  // The port idles with no strobe raised.
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 32'h00000000;
  end
  // One write: strobe for one edge, then data goes to its inverse.
  task automatic write_word(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    cfg_wdata <= ~d;
  endtask
  // One read: the answer stands only for the cycle after the taking edge, so
  // it is taken at the falling edge inside that cycle, before it is gone.
  task automatic read_word(input logic [7:0] a, output logic [31:0] d, output logic v);
    @(posedge core_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge core_clk);
    cfg_rd <= 1'b0;
    @(negedge core_clk);
    d = cfg_rdata;
    v = cfg_rvalid;
    @(posedge core_clk);
  endtask
  // A write and a read of the same word taken on two edges in a row.
  task automatic write_read(input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] d, output logic v);
    @(posedge core_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= wd;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b1;
    cfg_wdata <= ~wd;
    @(posedge core_clk);
    cfg_rd <= 1'b0;
    @(negedge core_clk);
    d = cfg_rdata;
    v = cfg_rvalid;
    @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// >>> dv/test_motor_lock_fault_config.sv
// Purpose: Self-checking bench for the motor lock fault settings block.
// Assumes: Outputs are compared half a cycle after the edge that moved them.
// Notes: Deglitch steps are 100 cycles, so clamp holds are sized from that.
`timescale 1ns/10ps
`default_nettype none
module test_motor_lock_fault_config;
  import mlfc_pkg::*;
  logic core_clk, rst_b, clk_en, cfg_wr, cfg_rd, cfg_rvalid, clamp_fault, fault_out_n;
  logic overspeed_hit, weak_backemf_hit, absent_motor_hit, clamp_hit;
  logic lock_retry_tick, fault_clear, v;
  logic [7:0] cfg_addr, overspeed_trip_pct;
  logic [31:0] cfg_wdata, cfg_rdata, d;
  logic [3:0] lock_response_select;
  logic [9:0] weak_backemf_trip_permille, absent_motor_current_ma;
  logic [2:0] lock_flags;
  mlfc_action_type gate_action;
  int num_errors = 0, n_compared = 0;
  int bemf[8] = '{400, 450, 500, 550, 600, 650, 675, 700};
  int amps[8] = '{75, 75, 100, 125, 250, 500, 750, 1000};
  int modes[5] = '{0, 1, 2, 3, 8};
  int acts[5] = '{1, 1, 2, 3, 0};
  mlfc_top mlfc_top_i (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .overspeed_hit(overspeed_hit), .weak_backemf_hit(weak_backemf_hit),
    .absent_motor_hit(absent_motor_hit), .clamp_hit(clamp_hit),
    .lock_retry_tick(lock_retry_tick), .fault_clear(fault_clear),
    .lock_response_select(lock_response_select), .overspeed_trip_pct(overspeed_trip_pct),
    .weak_backemf_trip_permille(weak_backemf_trip_permille),
    .absent_motor_current_ma(absent_motor_current_ma), .lock_flags(lock_flags),
    .clamp_fault(clamp_fault), .gate_action(gate_action), .fault_out_n(fault_out_n));
  mlfc_host_model mlfc_host_model_i (.core_clk(core_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));
  // Free-running 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Compares one value; unknown bits never count as a match.
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Reads a word and compares both the valid pulse and the data.
  task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
    mlfc_host_model_i.read_word(a, d, v);
    check_val({31'h0, v}, 32'h1);
    check_val(d, exp);
  endtask
  // Waits whole cycles, then moves to the falling edge where outputs are settled.
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog sized well above the roughly 450 cycles the sequence needs.
  initial begin
    #200000;
    num_errors++;
    test_done();
  end
  // Main sequence.
  initial begin
    {rst_b, overspeed_hit, weak_backemf_hit, absent_motor_hit, clamp_hit} = 5'h00;
    {lock_retry_tick, fault_clear} = 2'h0;
    clk_en = 1'b1;
    lock_response_select = 4'h8;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    read_check(MLFC_SETTINGS_OFFSET, MLFC_SETTINGS_RESET);
    mlfc_host_model_i.write_word(MLFC_SETTINGS_OFFSET, 32'hFFFFFFFF);
    read_check(MLFC_SETTINGS_OFFSET, 32'hFFFFFFFF);
    mlfc_host_model_i.write_word(8'h91, 32'h00000000);
    read_check(MLFC_SETTINGS_OFFSET, 32'hFFFFFFFF);
    read_check(8'h91, 32'h00000000);
    // Back-to-back write and read must return the new word.
    mlfc_host_model_i.write_read(MLFC_SETTINGS_OFFSET, 32'h5A5A5A5A, d, v);
    check_val({31'h0, v}, 32'h1);
    check_val(d, 32'h5A5A5A5A);
    // A write while the clock enable is low must not land.
    @(posedge core_clk);
    clk_en <= 1'b0;
    mlfc_host_model_i.write_word(MLFC_SETTINGS_OFFSET, 32'h00000000);
    @(posedge core_clk);
    clk_en <= 1'b1;
    read_check(MLFC_SETTINGS_OFFSET, 32'h5A5A5A5A);
    // Every threshold code, all three fields moving together.
    for (int c = 0; c < 8; c++) begin
      d = (32'(c) << 25) | (32'(c) << 22) | (32'(c) << 19);
      mlfc_host_model_i.write_word(MLFC_SETTINGS_OFFSET, d);
      read_check(MLFC_SETTINGS_OFFSET, d);
      hold(2);
      check_val(32'(overspeed_trip_pct), 32'(130 + 10 * c));
      check_val(32'(weak_backemf_trip_permille), 32'(bemf[c]));
      check_val(32'(absent_motor_current_ma), 32'(amps[c]));
    end
    // All detectors firing with every enable off and thresholds at maximum.
    mlfc_host_model_i.write_word(MLFC_SETTINGS_OFFSET, 32'h8FFFFFFF);
    @(posedge core_clk);
    {overspeed_hit, weak_backemf_hit, absent_motor_hit} <= 3'h7;
    hold(6);
    check_val(32'(lock_flags), 32'h0);
    check_val(32'(fault_out_n), 32'h1);
    // One enable at a time raises only its own flag.
    for (int i = 0; i < 3; i++) begin
      mlfc_host_model_i.write_word(MLFC_SETTINGS_OFFSET, 32'h40000000 >> i);
      hold(6);
      check_val(32'(lock_flags), 32'(3'h4 >> i));
      check_val(32'(fault_out_n), 32'h0);
    end
    @(posedge core_clk);
    {overspeed_hit, weak_backemf_hit, absent_motor_hit} <= 3'h0;
    mlfc_host_model_i.write_word(MLFC_SETTINGS_OFFSET, 32'h40000000);
    // Lock response modes: latched actions and report only.
    for (int m = 0; m < 5; m++) begin
      @(posedge core_clk);
      lock_response_select <= 4'(modes[m]);
      overspeed_hit <= 1'b1;
      hold(3);
      check_val(32'(gate_action), 32'(acts[m]));
      check_val(32'(fault_out_n), 32'h0);
      @(posedge core_clk);
      overspeed_hit <= 1'b0;
      hold(3);
    end
    // Latched clamp fault with a 1 us filter: a short glitch is dropped.
    mlfc_host_model_i.write_word(MLFC_SETTINGS_OFFSET, 32'h00001000);
    @(posedge core_clk);
    clamp_hit <= 1'b1;
    repeat (50) @(posedge core_clk);
    clamp_hit <= 1'b0;
    hold(20);
    check_val(32'(clamp_fault), 32'h0);
    @(posedge core_clk);
    clamp_hit <= 1'b1;
    hold(130);
    check_val(32'(clamp_fault), 32'h1);
    check_val(32'(fault_out_n), 32'h0);
    check_val(32'(gate_action), 32'(MLFC_ACT_TRISTATE));
    @(posedge core_clk);
    clamp_hit <= 1'b0;
    // Let the event drain out of the synchroniser and filter first, since an
    // event that meets the clear in one cycle wins over it.
    hold(5);
    check_val(32'(clamp_fault), 32'h1);
    @(posedge core_clk);
    fault_clear <= 1'b1;
    @(posedge core_clk);
    fault_clear <= 1'b0;
    hold(3);
    check_val(32'(clamp_fault), 32'h0);
    // Auto retry with a limit of one: first tick clears, second does not.
    mlfc_host_model_i.write_word(MLFC_SETTINGS_OFFSET, 32'h00020001);
    for (int r = 0; r < 2; r++) begin
      @(posedge core_clk);
      clamp_hit <= 1'b1;
      repeat (5) @(posedge core_clk);
      clamp_hit <= 1'b0;
      hold(5);
      check_val(32'(clamp_fault), 32'h1);
      @(posedge core_clk);
      lock_retry_tick <= 1'b1;
      @(posedge core_clk);
      lock_retry_tick <= 1'b0;
      hold(3);
      check_val(32'(clamp_fault), 32'(r));
    end
    // Response code 8 ignores the clamp event entirely.
    mlfc_host_model_i.write_word(MLFC_SETTINGS_OFFSET, 32'h00040000);
    @(posedge core_clk);
    fault_clear <= 1'b1;
    @(posedge core_clk);
    fault_clear <= 1'b0;
    clamp_hit <= 1'b1;
    hold(20);
    check_val(32'(clamp_fault), 32'h0);
    // A second reset in mid-run must bring the word back to zero.
    @(posedge core_clk);
    rst_b <= 1'b0;
    clamp_hit <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    read_check(MLFC_SETTINGS_OFFSET, MLFC_SETTINGS_RESET);
    check_val(32'(clamp_fault), 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
